/* design/trap_and_gpc_syndrome_encoder.sv */
// trap_and_gpc_syndrome_encoder: builds and captures the syndrome for matrix traps
// and protection check faults; assumes the pipeline raises one take at a time
// Operation
// [RQ1] matrix trap: code low three bits, rest zero
// [RQ2] code one: vector instruction while streaming
// [RQ3] code two: matrix instruction, streaming off
// [RQ4] code three: matrix instruction, array storage off
// [RQ5] code zero: enable control trap, unless class zero
// [RQ6] enable control traps use matrix class
// [RQ7] covers matrix, streaming vector, control register accesses
// [RQ8] enable controls trap by level scope
// [RQ9] stage two walk flag; high bits zero
// [RQ10] fetch flag set for instruction access
// [RQ11] status field; address size codes
// [RQ12] walk fault status codes
// [RQ13] granule fault status codes
// [RQ14] external abort status codes
// [RQ15] nested page flag for level one moves
// [RQ16] nested flag zero at level one, fetches
// [RQ17] cache maintenance flag for maintenance, translation
// [RQ18] zeroing instructions never set maintenance flag
// [RQ19] syndrome fields undefined after warm reset; reset clears matrixSynd and checkSynd to SYND_RESET (zero)
// [RQ20] stage one walk via stage two flag
// [RQ21] whole syndrome captured in one cycle
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module trap_and_gpc_syndrome_encoder
	import syndrome_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire matrix_trap_type matrixTrap,
	input wire check_fault_type checkFault,
	input wire logic nestedVirtFeature,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	output synd_out_type syndOut,
	output logic badTrapScope
);
	typedef struct packed {
		logic [24:0] matrixSynd;
		logic [24:0] checkSynd;
		synd_out_type out;
		logic [31:0] cfg;
		logic [31:0] rdData;
		logic [7:0] takenCount;
		logic scopeErr;
	} state_type;

	state_type s_r;
	state_type s_nxt;
	logic [24:0] checkSyndComb;

	check_syndrome_enc encoder (
		.fault(checkFault),
		.nestedVirtFeature(nestedVirtFeature & s_r.cfg[0]),
		.syndrome(checkSyndComb)
	);

	function automatic logic [2:0] trap_code(matrix_cause_type c);
		logic [2:0] code;
		code = TRAP_CTRL;
		case (c)
			CAUSE_STREAM_ON: code = TRAP_STREAM_ON; // [RQ2]
			CAUSE_STREAM_OFF: code = TRAP_STREAM_OFF; // [RQ3]
			CAUSE_ARRAY_OFF: code = TRAP_ARRAY_OFF; // [RQ4]
			default: code = TRAP_CTRL; // [RQ5]
		endcase
		return code;
	endfunction

	// level scope: ctrlLevel 1 traps from 0/1, 2 from 0..2, 3 from all
	function automatic logic scope_ok(logic [1:0] ctrl, logic [1:0] from);
		return (ctrl != 2'h0) && (from <= ctrl);
	endfunction

	always_comb begin
		s_nxt = s_r;
		s_nxt.rdData = 32'h0000_0000;
		s_nxt.out.valid = 1'b0;
		if (matrixTrap.take) begin
			s_nxt.matrixSynd = {22'h00_0000, trap_code(matrixTrap.cause)}; // [RQ1] [RQ7]
			s_nxt.out.syndrome = {22'h00_0000, trap_code(matrixTrap.cause)}; // [RQ21]
			s_nxt.out.valid = 1'b1;
			s_nxt.takenCount = s_r.takenCount + 8'h01;
			if (matrixTrap.cause == CAUSE_CTRL && matrixTrap.ctrlUnknownClass) begin
				s_nxt.out.exceptionClass = CLASS_UNKNOWN; // [RQ5]
			end else begin
				s_nxt.out.exceptionClass = CLASS_MATRIX; // [RQ6]
			end
			if (matrixTrap.cause == CAUSE_CTRL) begin
				s_nxt.scopeErr = ~scope_ok(matrixTrap.ctrlLevel, matrixTrap.fromLevel); // [RQ8]
			end else begin
				s_nxt.scopeErr = 1'b0;
			end
		end else if (checkFault.take) begin
			s_nxt.checkSynd = checkSyndComb; // [RQ21]
			s_nxt.out.syndrome = checkSyndComb;
			s_nxt.out.exceptionClass = CLASS_PROTECT;
			s_nxt.out.valid = 1'b1;
			s_nxt.takenCount = s_r.takenCount + 8'h01;
			s_nxt.scopeErr = 1'b0;
		end
		if (regWr) begin
			if (regAddr == ADDR_CONFIG) begin
				s_nxt.cfg = regWrData;
			end else if (regAddr == ADDR_TAKEN) begin
				// a take in the clearing cycle still counts
				s_nxt.takenCount = {7'h00, matrixTrap.take | checkFault.take};
			end
		end
		if (regRd) begin
			if (regAddr == ADDR_MATRIX) begin
				s_nxt.rdData = {7'h00, s_r.matrixSynd};
			end else if (regAddr == ADDR_PROTECT) begin
				s_nxt.rdData = {7'h00, s_r.checkSynd};
			end else if (regAddr == ADDR_TAKEN) begin
				s_nxt.rdData = {24'h00_0000, s_r.takenCount};
			end else if (regAddr == ADDR_CONFIG) begin
				s_nxt.rdData = s_r.cfg;
			end else begin
				s_nxt.rdData = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_r.out <= '0;
			s_r.cfg <= CONFIG_RESET;
			s_r.rdData <= 32'h0000_0000;
			s_r.takenCount <= 8'h00;
			s_r.scopeErr <= 1'b0;
			s_r.matrixSynd <= SYND_RESET; // [RQ19]
			s_r.checkSynd <= SYND_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign regRdData = s_r.rdData;
	assign syndOut = s_r.out;
	assign badTrapScope = s_r.scopeErr;
endmodule
`default_nettype wire

/* pkg/syndrome_pkg.sv */
// syndrome_pkg: field positions, codes and register offsets of the syndrome encoder
// assumes one 10 MHz core clock and a plain register port
`default_nettype none
package syndrome_pkg;
	localparam int SYND_W = 25;
	localparam int TRAP_CODE_LSB = 0;
	localparam int WALK2_BIT = 21;
	localparam int FETCH_BIT = 20;
	localparam int STATUS_LSB = 14;
	localparam int NESTED_BIT = 13;
	localparam int CMAINT_BIT = 8;
	localparam int WALK1_BIT = 7;
	localparam logic [2:0] TRAP_CTRL = 3'h0;
	localparam logic [2:0] TRAP_STREAM_ON = 3'h1;
	localparam logic [2:0] TRAP_STREAM_OFF = 3'h2;
	localparam logic [2:0] TRAP_ARRAY_OFF = 3'h3;
	localparam logic [5:0] CLASS_MATRIX = 6'h1D;
	localparam logic [5:0] CLASS_UNKNOWN = 6'h00;
	localparam logic [5:0] CLASS_PROTECT = 6'h1E;
	localparam logic [5:0] ST_ADDR_SIZE = 6'h00;
	localparam logic [5:0] ST_WALK = 6'h04;
	localparam logic [5:0] ST_GRANULE = 6'h0C;
	localparam logic [5:0] ST_EXT_ABORT = 6'h14;
	localparam logic [3:0] ADDR_MATRIX = 4'h0;
	localparam logic [3:0] ADDR_PROTECT = 4'h1;
	localparam logic [3:0] ADDR_TAKEN = 4'h2;
	localparam logic [3:0] ADDR_CONFIG = 4'h3;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0001;
	localparam logic [24:0] SYND_RESET = 25'h000_0000;
	typedef enum logic [1:0] {
		CAUSE_CTRL = 2'h0,
		CAUSE_STREAM_ON = 2'h1,
		CAUSE_STREAM_OFF = 2'h3,
		CAUSE_ARRAY_OFF = 2'h2
	} matrix_cause_type;
	typedef enum logic [1:0] {
		KIND_ADDR_SIZE = 2'h0,
		KIND_WALK = 2'h1,
		KIND_GRANULE = 2'h3,
		KIND_EXT_ABORT = 2'h2
	} check_kind_type;
	typedef struct packed {
		logic take;
		matrix_cause_type cause;
		logic ctrlUnknownClass;
		logic [1:0] ctrlLevel;
		logic [1:0] fromLevel;
	} matrix_trap_type;
	typedef struct packed {
		logic take;
		logic stage2Walk;
		logic stage1ViaStage2;
		logic instrFetch;
		check_kind_type kind;
		logic level1;
		logic nestedPageUse;
		logic fromEl1;
		logic toEl1;
		logic cacheMaint;
		logic addrTranslate;
		logic zeroBlock;
	} check_fault_type;
	typedef struct packed {
		logic valid;
		logic [5:0] exceptionClass;
		logic [24:0] syndrome;
	} synd_out_type;
	function automatic logic [5:0] status_code(check_kind_type k, logic lvl1);
		logic [5:0] base;
		base = ST_ADDR_SIZE;
		case (k)
			KIND_WALK: base = ST_WALK;
			KIND_GRANULE: base = ST_GRANULE;
			KIND_EXT_ABORT: base = ST_EXT_ABORT;
			default: base = ST_ADDR_SIZE;
		endcase
		return base | {5'h00, lvl1};
	endfunction
endpackage
`default_nettype wire

/* design/check_syndrome_enc.sv */
// check_syndrome_enc: combinational encoder of the protection check syndrome
// assumes the fault descriptor is steady in the cycle it is taken
`timescale 1ns/1ps
`default_nettype none
module check_syndrome_enc
	import syndrome_pkg::*;
(
	input wire check_fault_type fault,
	input wire logic nestedVirtFeature,
	output logic [24:0] syndrome
);
	always_comb begin
		syndrome = SYND_RESET;
		syndrome[WALK2_BIT] = fault.stage2Walk; // [RQ9]
		syndrome[FETCH_BIT] = fault.instrFetch; // [RQ10]
		syndrome[STATUS_LSB +: 6] = status_code(fault.kind, fault.level1); // [RQ11] [RQ12] [RQ13] [RQ14]
		syndrome[NESTED_BIT] = nestedVirtFeature & fault.nestedPageUse & fault.fromEl1
			& ~fault.toEl1 & ~fault.instrFetch; // [RQ15] [RQ16]
		syndrome[CMAINT_BIT] = (fault.cacheMaint | fault.addrTranslate)
			& ~fault.zeroBlock; // [RQ17] [RQ18]
		syndrome[WALK1_BIT] = fault.stage1ViaStage2; // [RQ20]
	end
endmodule
`default_nettype wire

/* verif/enc_assertions.sv */
// enc_assertions: port checks of the syndrome encoder
// assumes a bind into the encoder top
`timescale 1ns/1ps
`default_nettype none
module enc_assertions
	import syndrome_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire matrix_trap_type matrixTrap,
	input wire check_fault_type checkFault,
	input wire synd_out_type syndOut
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire logic mt = matrixTrap.take;
	wire logic cf = checkFault.take && !mt;
	wire logic [24:0] s = syndOut.syndrome;
	property p_take; mt || cf |=> syndOut.valid; endproperty
	a_take: assert property (p_take) else $error("no valid");
	property p_mz; mt |=> s[24:3] == 22'h0; endproperty
	a_mz: assert property (p_mz) else $error("high bits");
	property p_on; mt && matrixTrap.cause == CAUSE_STREAM_ON |=> s[2:0] == 3'h1; endproperty
	a_on: assert property (p_on) else $error("code one");
	property p_cls; mt && !matrixTrap.ctrlUnknownClass |=> syndOut.exceptionClass == 6'h1D;
	endproperty
	a_cls: assert property (p_cls) else $error("class");
	property p_gz; cf |=> s[24:22] == 3'h0 && s[12:9] == 4'h0; endproperty
	a_gz: assert property (p_gz) else $error("zero bits");
	property p_ind; cf |=> s[20] == $past(checkFault.instrFetch); endproperty
	a_ind: assert property (p_ind) else $error("fetch flag");
	property p_nv; cf && (checkFault.instrFetch || checkFault.toEl1) |=> !s[13]; endproperty
	a_nv: assert property (p_nv) else $error("nested flag");
	property p_cm; cf && checkFault.zeroBlock |=> !s[8]; endproperty
	a_cm: assert property (p_cm) else $error("maint flag");
	c_m: cover property (mt);
	c_c: cover property (cf);
	c_both: cover property (mt && checkFault.take);
endmodule
`default_nettype wire

/* verif/pipe_model.sv */
// pipe_model: pipeline side raising one take pulse
// assumes take is sampled on the rising edge
`timescale 1ns/1ps
`default_nettype none
module pipe_model
	import syndrome_pkg::*;
(
	input wire logic clk,
	output matrix_trap_type mt,
	output check_fault_type cf
);
	initial begin
		mt = '0;
		cf = '0;
	end
	task send(input matrix_trap_type m, input check_fault_type c);
		@(posedge clk);
		mt <= m;
		cf <= c;
		@(posedge clk);
		mt.take <= 1'b0;
		cf.take <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// tb: register port and pipeline traffic into the encoder
// assumes 10 MHz sys_clk, synchronous active low reset
`timescale 1ns/1ps
`default_nettype none
module tb
	import syndrome_pkg::*;
;
	logic sys_clk = 0, rst_n = 0, nv = 1, regWr = 0, regRd = 0, badTrapScope;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0, regRdData, e;
	matrix_trap_type mt, m;
	check_fault_type cf, c;
	synd_out_type syndOut;
	logic [2:0] code [4] = '{3'h0, 3'h1, 3'h3, 3'h2};
	logic [5:0] base [4] = '{6'h00, 6'h04, 6'h14, 6'h0C};
	int n_errors = 0, checked = 0;
	always #50 sys_clk = ~sys_clk;
	pipe_model pipe_model_i(.clk(sys_clk), .mt(mt), .cf(cf));
	trap_and_gpc_syndrome_encoder trap_and_gpc_syndrome_encoder_i(.sys_clk(sys_clk),
		.rst_n(rst_n), .matrixTrap(mt), .checkFault(cf), .nestedVirtFeature(nv),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .syndOut(syndOut), .badTrapScope(badTrapScope));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task snd(input logic [31:0] exp);
		pipe_model_i.send(m, c);
		#1 chk(syndOut, exp);
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] x);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 chk(regRdData, x);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#1000000;
		n_errors++;
		test_done;
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(ADDR_CONFIG, 32'h1);
		c = '0;
		for (int i = 0; i < 4; i++) begin
			m = '0;
			m.take = 1'b1;
			m.ctrlLevel = 2'h3;
			m.cause = matrix_cause_type'(i);
			snd({1'b1, 6'h1D, 22'h0, code[i]});
			chk(badTrapScope, 32'h0);
		end
		m.cause = CAUSE_CTRL;
		m.ctrlUnknownClass = 1'b1;
		m.ctrlLevel = 2'h1;
		m.fromLevel = 2'h2;
		snd({1'b1, 6'h00, 25'h0});
		chk(badTrapScope, 32'h1);
		m.cause = CAUSE_STREAM_OFF;
		m.ctrlUnknownClass = 1'b0;
		c.take = 1'b1;
		snd({1'b1, 6'h1D, 22'h0, 3'h2});
		chk(badTrapScope, 32'h0);
		wr(ADDR_MATRIX, 32'hFFFF_FFFF);
		rd(ADDR_MATRIX, 32'h2);
		$display("matrix trap test done");
		m = '0;
		for (int i = 0; i < 8; i++) begin
			c = '0;
			c.take = 1'b1;
			c.kind = check_kind_type'(i[1:0]);
			{c.level1, c.stage1ViaStage2, c.stage2Walk} = i[2:0];
			c.instrFetch = i[2];
			c.cacheMaint = ~i[2];
			e = {1'b1, CLASS_PROTECT, 3'h0, i[0], i[2], base[i[1:0]] | {5'h0, i[2]}, 5'h0, 9'h0};
			snd({e[31:9], ~i[2], i[1], 7'h0});
		end
		c = '0;
		c.take = 1'b1;
		c.fromEl1 = 1'b1;
		c.nestedPageUse = 1'b1;
		wr(ADDR_TAKEN, 32'h0);
		snd({1'b1, CLASS_PROTECT, 11'h0, 1'b1, 13'h0});
		c.toEl1 = 1'b1;
		c.zeroBlock = 1'b1;
		c.cacheMaint = 1'b1;
		snd({1'b1, CLASS_PROTECT, 25'h0});
		{c.toEl1, c.zeroBlock, c.cacheMaint, c.addrTranslate} = 4'h1;
		wr(ADDR_CONFIG, 32'h0);
		snd({1'b1, CLASS_PROTECT, 16'h0, 1'b1, 8'h0});
		rd(ADDR_PROTECT, 32'h0000_0100);
		rd(ADDR_TAKEN, 32'h3);
		rd(4'h9, 32'h0);
		$display("protection check test done");
		test_done;
	end
endmodule
bind trap_and_gpc_syndrome_encoder enc_assertions chk_i(.sys_clk(sys_clk), .rst_n(rst_n),
	.matrixTrap(matrixTrap), .checkFault(checkFault), .syndOut(syndOut));
`default_nettype wire
